//--- verilog/lddiag_pkg.sv
`default_nettype none

package lddiag_pkg;

  // Register addresses on the serial control port.
  localparam logic [7:0] ADDR_CMD      = 8'h01;
  localparam logic [7:0] ADDR_GSTAT    = 8'h02;
  localparam logic [7:0] ADDR_LSTAT    = 8'h03;
  localparam logic [7:0] ADDR_RSTAT    = 8'h04;
  localparam logic [7:0] ADDR_IND      = 8'h05;
  localparam logic [7:0] ADDR_GEN_EN   = 8'h06;
  localparam logic [7:0] ADDR_LEFT_EN  = 8'h07;
  localparam logic [7:0] ADDR_RIGHT_EN = 8'h08;

  // Reset values; every register except the indicator's type field powers up clear.
  localparam logic [7:0] REG_RESET  = 8'h00;

  // Writable positions of the mask registers.
  localparam logic [7:0] CH_WMASK   = 8'hEC;
  localparam logic [7:0] GEN_WMASK  = 8'h70;

  // Command byte fields.
  localparam int unsigned CMD_LEFT_REENABLE  = 7;
  localparam int unsigned CMD_RIGHT_REENABLE = 6;

  // Auto-retry period: 500 ms at a 200 MHz clock.
  localparam int unsigned RETRY_MS         = 500;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned RETRY_CYCLES_DEF = RETRY_MS * 1000 * CLK_MHZ;
  localparam int unsigned RETRY_CNT_W      = 27;

  // One channel's detector outputs, in status-bit order.
  typedef struct packed {
    logic supply_short;
    logic ground_short;
    logic overcurrent;
    logic offset;
    logic open_load;
  } lddiag_det_t;

  // Every input that arrives from outside the clock domain.
  typedef struct packed {
    logic        diagnostic_enable;
    logic        standalone;
    logic        temp_warning;
    logic        thermal_shutdown;
    logic        overvoltage;
    lddiag_det_t left;
    lddiag_det_t right;
  } lddiag_pins_t;

  // Register access strobes as decoded from the serial interface.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lddiag_req_t;

endpackage : lddiag_pkg

`default_nettype wire

//--- verilog/lddiag_top.sv
`default_nettype none

// Summary of operation
// - Right mask resets zero; bits 7,6,5,3,2 enable right detectors; bit 4 zero.
// - Detection records only with diagnostic enable and the matching mask bit set.
// - Detected faults report via status registers, summary bit and indicator pin.
// - Stand-alone mode retries faulted channels every 500 ms until fault clears.
// - Stand-alone mode pulses the fault indicator instead of holding it low.
// - Short to supply switches the channel off to high impedance, unmaskable.
// - Unmasked short to supply sets its status bit until that register is read.
// - After short shutdown the channel stays off until its re-enable bit is written or a stand-alone retry comes.
// - Short to ground switches the channel off to high impedance, unmaskable.
// - Unmasked short to ground sets its status bit; reading the register clears it.
// - Temperature warning bit clears only once cool and general status is read.
// - Thermal shutdown bit clears once cool and read; stand-alone retries it.
// - Thermal shutdown turns both channels off; each returns on its own re-enable.
// - A recorded fault sets the summary bit; in host mode it also drives the indicator low.
// - Command byte at 0x01: bit 7 re-enables left, bit 6 re-enables right.
// - Channel status at 0x03 and 0x04 with the documented bit layout, reset zero.
// - Host mode holds the indicator low while any channel status bit is high.
// - General status at 0x02: warning bit 6, shutdown bit 5, overvoltage bit 4.

module lddiag_top
  import lddiag_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYCLES_DEF,
  // Device type code; the value is arbitrary.
  parameter logic [2:0]  DEVICE_TYPE  = 3'h1
)
(
  input  wire logic          sys_clk_in,
  input  wire logic          sys_rst_in,
  input  wire lddiag_pins_t  pins_in,
  input  wire lddiag_req_t   req_in,
  output logic [7:0]         rdata_out,
  output logic               rvalid_out,
  output logic               fault_n_out,
  output logic               left_highz_out,
  output logic               right_highz_out
);

  // Packs a channel's detectors into the status register layout.
  function automatic logic [7:0] ch_byte(input lddiag_det_t d);
    ch_byte = {d.supply_short, d.ground_short, d.overcurrent, 1'b0,
               d.offset, d.open_load, 2'b00};
  endfunction

  // Address compare shared by every decode below.
  function automatic logic hit(input lddiag_req_t r,
                               input logic [7:0]  a);
    hit = (r.addr == a);
  endfunction

  lddiag_pins_t             meta_ff;
  lddiag_pins_t             live_ff;
  logic [7:0]               gen_en_ff;
  logic [7:0]               left_en_ff;
  logic [7:0]               right_en_ff;
  logic [7:0]               gstat_ff;
  logic [7:0]               lstat_ff;
  logic [7:0]               rstat_ff;
  logic                     left_off_ff;
  logic                     right_off_ff;
  logic [RETRY_CNT_W-1:0]   retry_cnt_ff;
  logic                     blink_ff;
  logic [7:0]               rdata_ff;
  logic                     rvalid_ff;
  logic                     fault_n_ff;

  // The analog detectors and mode straps are asynchronous to this clock.
  always_ff @(posedge sys_clk_in)
  begin
    meta_ff <= pins_in;
    live_ff <= meta_ff;
  end

  // Register write and read decode.
  wire wr_cmd      = req_in.wr & hit(req_in, ADDR_CMD);
  wire wr_gen_en   = req_in.wr & hit(req_in, ADDR_GEN_EN);
  wire wr_left_en  = req_in.wr & hit(req_in, ADDR_LEFT_EN);
  wire wr_right_en = req_in.wr & hit(req_in, ADDR_RIGHT_EN);
  wire rd_gstat    = req_in.rd & hit(req_in, ADDR_GSTAT);
  wire rd_lstat    = req_in.rd & hit(req_in, ADDR_LSTAT);
  wire rd_rstat    = req_in.rd & hit(req_in, ADDR_RSTAT);

  // Only the defined enable positions are stored.
  wire [7:0] nxt_gen_en   = wr_gen_en ? (req_in.wdata & GEN_WMASK) : gen_en_ff;
  wire [7:0] nxt_left_en  = wr_left_en ? (req_in.wdata & CH_WMASK) : left_en_ff;
  wire [7:0] nxt_right_en = wr_right_en ? (req_in.wdata & CH_WMASK) : right_en_ff;

  // Mode qualifiers after synchronisation.
  wire diagnostics_on = live_ff.diagnostic_enable;
  wire sa_mode        = live_ff.standalone;

  // Raw detector bytes, laid out as their status registers.
  wire [7:0] left_live  = ch_byte(live_ff.left);
  wire [7:0] right_live = ch_byte(live_ff.right);
  wire [7:0] gen_live   = {1'b0, live_ff.temp_warning, live_ff.thermal_shutdown,
                           live_ff.overvoltage, 4'h0};

  // A detection is recorded only in diagnostic mode and when unmasked.
  wire [7:0] left_set  = left_live & left_en_ff & {8{diagnostics_on}};
  wire [7:0] right_set = right_live & right_en_ff & {8{diagnostics_on}};
  wire [7:0] gen_set   = gen_live & gen_en_ff & {8{diagnostics_on}};

  // Reads clear, but a detection in the same cycle wins over the clear.
  // A persisting temperature condition therefore survives every read.
  wire [7:0] nxt_lstat = left_set | (lstat_ff & ~{8{rd_lstat}});
  wire [7:0] nxt_rstat = right_set | (rstat_ff & ~{8{rd_rstat}});
  wire [7:0] nxt_gstat = gen_set | (gstat_ff & ~{8{rd_gstat}});

  // Summary of every recorded fault.
  wire any_ch_fault = (|lstat_ff) | (|rstat_ff);
  wire summary      = any_ch_fault | (|gstat_ff);

  // Unmaskable shutdown sources per channel; thermal shutdown hits both.
  wire left_kill  = live_ff.left.supply_short | live_ff.left.ground_short
                    | live_ff.thermal_shutdown;
  wire right_kill = live_ff.right.supply_short | live_ff.right.ground_short
                    | live_ff.thermal_shutdown;

  // Stand-alone retry timing runs while any fault or shutdown is present.
  wire any_live    = (|left_live) | (|right_live) | (|gen_live);
  wire retry_run   = sa_mode & (left_off_ff | right_off_ff | any_live);
  wire retry_wrap  = (retry_cnt_ff == RETRY_CNT_W'(RETRY_CYCLES - 1));
  wire auto_retry  = retry_run & retry_wrap;
  wire [RETRY_CNT_W-1:0] nxt_retry_cnt =
    (!retry_run || retry_wrap) ? '0 : retry_cnt_ff + RETRY_CNT_W'(1);

  // Re-enable requests from the host or from the retry timer.
  wire left_retry  = (wr_cmd & req_in.wdata[CMD_LEFT_REENABLE]) | auto_retry;
  wire right_retry = (wr_cmd & req_in.wdata[CMD_RIGHT_REENABLE]) | auto_retry;

  // A short or thermal shutdown still present when the retry comes keeps the channel off.
  wire nxt_left_off  = left_kill | (left_off_ff & ~left_retry);
  wire nxt_right_off = right_kill | (right_off_ff & ~right_retry);

  // The blink phase starts high so a new stand-alone fault drives the pin low at once.
  wire nxt_blink = retry_run ? (blink_ff ^ auto_retry) : 1'b1;

  // Host mode holds the pin low; stand-alone mode pulses it per period.
  wire nxt_fault_n = sa_mode ? ~(retry_run & blink_ff) : ~summary;

  // Indicator register: summary, high-impedance states, offsets, type.
  wire [7:0] ind_byte = {summary, left_off_ff, right_off_ff,
                         lstat_ff[3], rstat_ff[3], DEVICE_TYPE};

  // Read multiplexer; the command byte and unmapped addresses read zero.
  wire [7:0] rd_mux =
    hit(req_in, ADDR_GSTAT) ? gstat_ff :
    hit(req_in, ADDR_LSTAT) ? lstat_ff :
    hit(req_in, ADDR_RSTAT) ? rstat_ff :
    hit(req_in, ADDR_IND)   ? ind_byte :
    hit(req_in, ADDR_GEN_EN)   ? gen_en_ff :
    hit(req_in, ADDR_LEFT_EN)  ? left_en_ff :
    hit(req_in, ADDR_RIGHT_EN) ? right_en_ff : REG_RESET;

  // Read data holds its last value between reads.
  wire [7:0] nxt_rdata = req_in.rd ? rd_mux : rdata_ff;

  // Mask registers.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      gen_en_ff   <= REG_RESET;
      left_en_ff  <= REG_RESET;
      right_en_ff <= REG_RESET;
    end
    else
    begin
      gen_en_ff   <= nxt_gen_en;
      left_en_ff  <= nxt_left_en;
      right_en_ff <= nxt_right_en;
    end
  end

  // Sticky fault status registers.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      gstat_ff <= REG_RESET;
      lstat_ff <= REG_RESET;
      rstat_ff <= REG_RESET;
    end
    else
    begin
      gstat_ff <= nxt_gstat;
      lstat_ff <= nxt_lstat;
      rstat_ff <= nxt_rstat;
    end
  end

  // Channel shutdown latches.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      left_off_ff  <= 1'b0;
      right_off_ff <= 1'b0;
    end
    else
    begin
      left_off_ff  <= nxt_left_off;
      right_off_ff <= nxt_right_off;
    end
  end

  // Retry timer and indicator blink phase.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      retry_cnt_ff <= '0;
      blink_ff     <= 1'b1;
    end
    else
    begin
      retry_cnt_ff <= nxt_retry_cnt;
      blink_ff     <= nxt_blink;
    end
  end

  // Registered outputs toward the serial interface and the pin.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_ff   <= REG_RESET;
      rvalid_ff  <= 1'b0;
      fault_n_ff <= 1'b1;
    end
    else
    begin
      rdata_ff   <= nxt_rdata;
      rvalid_ff  <= req_in.rd;
      fault_n_ff <= nxt_fault_n;
    end
  end

  assign rdata_out       = rdata_ff;
  assign rvalid_out      = rvalid_ff;
  assign fault_n_out     = fault_n_ff;
  assign left_highz_out  = left_off_ff;
  assign right_highz_out = right_off_ff;

endmodule // lddiag_top

`default_nettype wire

//--- dv/lddiag_top_asserts.sv
`default_nettype none
module lddiag_top_asserts
  import lddiag_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = 16
)
(
  input wire logic         sys_clk_in,
  input wire logic         sys_rst_in,
  input wire lddiag_pins_t pins_in,
  input wire lddiag_req_t  req_in,
  input wire logic [7:0]   rdata_out,
  input wire logic         rvalid_out,
  input wire logic         fault_n_out,
  input wire logic         left_highz_out,
  input wire logic         right_highz_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // A re-enable write for the left channel, decoded once for the release check.
  wire logic cmd_left = req_in.wr && (req_in.addr == ADDR_CMD) && req_in.wdata[7];
  // Pin levels need three edges to get through the synchroniser and act.
  sequence s_held(logic b);
    b [*3];
  endsequence
  a_read_answer: assert property (rvalid_out == $past(req_in.rd))
    else $error("read answer not one cycle after the read");
  a_cmd_reads_zero: assert property (req_in.rd && req_in.addr == ADDR_CMD |=>
    rdata_out == 8'h00) else $error("command byte did not read zero");
  a_mask_fixed_zero: assert property (req_in.rd && req_in.addr == ADDR_RIGHT_EN |=>
    (rdata_out & 8'h13) == 8'h00) else $error("fixed mask bits read nonzero");
  a_supply_kill_left: assert property (s_held(pins_in.left.supply_short) |=>
    left_highz_out) else $error("left not off on supply short");
  a_ground_kill_right: assert property (s_held(pins_in.right.ground_short) |=>
    right_highz_out) else $error("right not off on ground short");
  a_thermal_both_off: assert property (s_held(pins_in.thermal_shutdown) |=>
    left_highz_out && right_highz_out) else $error("thermal shutdown left a channel on");
  a_left_release_cmd: assert property ($fell(left_highz_out) && !pins_in.standalone &&
    !$past(pins_in.standalone, 3) && !$past(pins_in.standalone, 4) |-> $past(cmd_left))
    else $error("left channel returned without a re-enable write");
  a_fault_clear_read: assert property ($rose(fault_n_out) && !pins_in.standalone &&
    !$past(pins_in.standalone, 3) && !$past(pins_in.standalone, 4) |->
    $past(req_in.rd, 2) || $past(req_in.rd, 3))
    else $error("fault indicator released without a status read");
endmodule // lddiag_top_asserts
bind lddiag_top lddiag_top_asserts #(.RETRY_CYCLES(RETRY_CYCLES)) u_asserts (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .pins_in(pins_in), .req_in(req_in),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out), .fault_n_out(fault_n_out),
  .left_highz_out(left_highz_out), .right_highz_out(right_highz_out));
`default_nettype wire

//--- dv/lddiag_host_model.sv
`default_nettype none
module lddiag_host_model
  import lddiag_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  output var lddiag_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle host: no strobes until the bench asks for an access.
  initial req_out = '0;
  // Single-cycle write strobe, the way the serial decoder hands writes over.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out.wr    <= 1'b1;
    req_out.addr  <= a;
    req_out.wdata <= d;
    @(posedge clk_in);
    req_out.wr <= 1'b0;
  endtask
  // Read strobe, then a bounded wait for the answer so a dead port cannot hang.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    int n = 0;
    @(posedge clk_in);
    req_out.rd   <= 1'b1;
    req_out.addr <= a;
    @(posedge clk_in);
    req_out.rd <= 1'b0;
    #1;
    while (rvalid_in !== 1'b1 && n < 3)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    // A missing answer hands back unknowns so that the compare fails.
    if (rvalid_in === 1'b1)
      d = rdata_in;
    else
      d = 'x;
  endtask
endmodule // lddiag_host_model
`default_nettype wire

//--- dv/line_driver_fault_diagnostics_test.sv
`default_nettype none
module line_driver_fault_diagnostics_test;
  timeunit 1ns;
  timeprecision 1ps;
  import lddiag_pkg::*;
  logic         sys_clk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  lddiag_pins_t pins       = '0;
  lddiag_req_t  req;
  logic [7:0]   rdata, d;
  logic         rvalid, fault_n, lhz, rhz;
  int           n_mismatch = 0, check_count = 0, lo = 0, hi = 0;
  logic [7:0]   ra [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h3F};
  // Free-running clock.
  always #2.5 sys_clk_in = ~sys_clk_in;
  // A short retry period keeps the stand-alone case quick.
  // The device type code is arbitrary.
  lddiag_top #(.RETRY_CYCLES(16), .DEVICE_TYPE(3'h3)) uut (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .pins_in(pins), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .fault_n_out(fault_n), .left_highz_out(lhz), .right_highz_out(rhz));
  lddiag_host_model host (.clk_in(sys_clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .req_out(req));
  // Comparison, counting and reporting.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, d);
    chk(d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short; the whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    n_mismatch++;
    final_report();
  end
  // Main sequence; pins change on the rising edge and settle through the synchroniser.
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    foreach (ra[i]) rchk(ra[i], 8'h00);
    rchk(ADDR_IND, 8'h03);
    host.wr_reg(ADDR_RIGHT_EN, 8'hFF);
    rchk(ADDR_RIGHT_EN, 8'hEC);
    host.wr_reg(ADDR_LEFT_EN, 8'hFF);
    rchk(ADDR_LEFT_EN, 8'hEC);
    host.wr_reg(ADDR_GEN_EN, 8'hFF);
    rchk(ADDR_GEN_EN, 8'h70);
    host.wr_reg(ADDR_LSTAT, 8'hFF);
    rchk(ADDR_LSTAT, 8'h00);
    @(posedge sys_clk_in) pins.left.supply_short <= 1'b1;
    cyc(6);
    chk(8'(lhz), 8'h01);
    rchk(ADDR_LSTAT, 8'h00);
    @(posedge sys_clk_in) pins.diagnostic_enable <= 1'b1;
    cyc(6);
    chk(8'(fault_n), 8'h00);
    rchk(ADDR_IND, 8'hC3);
    rchk(ADDR_LSTAT, 8'h80);
    @(posedge sys_clk_in) pins.left.supply_short <= 1'b0;
    cyc(5);
    rchk(ADDR_LSTAT, 8'h80);
    rchk(ADDR_LSTAT, 8'h00);
    cyc(3);
    chk(8'(fault_n), 8'h01);
    host.wr_reg(ADDR_CMD, 8'h40);
    cyc(2);
    chk(8'(lhz), 8'h01);
    host.wr_reg(ADDR_CMD, 8'h80);
    cyc(2);
    chk(8'(lhz), 8'h00);
    @(posedge sys_clk_in) pins.right.ground_short <= 1'b1;
    cyc(6);
    chk(8'(rhz), 8'h01);
    @(posedge sys_clk_in) pins.right.ground_short <= 1'b0;
    cyc(5);
    rchk(ADDR_RSTAT, 8'h40);
    rchk(ADDR_RSTAT, 8'h00);
    host.wr_reg(ADDR_CMD, 8'h40);
    cyc(2);
    chk(8'(rhz), 8'h00);
    @(posedge sys_clk_in) pins.left <= 5'b00111;
    cyc(6);
    rchk(ADDR_LSTAT, 8'h2C);
    chk(8'(lhz), 8'h00);
    @(posedge sys_clk_in) pins.left <= 5'b00000;
    cyc(5);
    rchk(ADDR_LSTAT, 8'h2C);
    @(posedge sys_clk_in) pins[12:10] <= 3'b111;
    cyc(6);
    chk({6'h00, lhz, rhz}, 8'h03);
    rchk(ADDR_GSTAT, 8'h70);
    rchk(ADDR_GSTAT, 8'h70);
    @(posedge sys_clk_in) pins[12:10] <= 3'b000;
    cyc(5);
    rchk(ADDR_GSTAT, 8'h70);
    rchk(ADDR_GSTAT, 8'h00);
    host.wr_reg(ADDR_CMD, 8'h80);
    cyc(2);
    chk({6'h00, lhz, rhz}, 8'h01);
    host.wr_reg(ADDR_CMD, 8'h40);
    cyc(2);
    chk({6'h00, lhz, rhz}, 8'h00);
    @(posedge sys_clk_in) pins.standalone <= 1'b1;
    pins.left.supply_short <= 1'b1;
    cyc(6);
    // The fault persists over two and a half retry periods, so the pin must toggle.
    repeat (40)
    begin
      cyc(1);
      if (fault_n === 1'b0)
        lo++;
      else if (fault_n === 1'b1)
        hi++;
    end
    chk(8'(lhz), 8'h01);
    chk(8'(lo > 0 && hi > 0), 8'h01);
    @(posedge sys_clk_in) pins.left.supply_short <= 1'b0;
    cyc(40);
    chk(8'(lhz), 8'h00);
    chk(8'(fault_n), 8'h01);
    final_report();
  end
endmodule // line_driver_fault_diagnostics_test
`default_nettype wire
